// *** logic/kpd_defines.svh ***
// Constants for the keypad input conditioning block: sizes, timing and register offsets.
// Assumes a 4 ns system clock; the debounce and scan counts are derived from it.
`ifndef KPD_DEFINES_SVH
`define KPD_DEFINES_SVH

`define NPINS          18
`define NROWS          8
`define NCOLS          10
`define NKEYS          80
`define KEY_ROW_STRIDE 10
`define COMBO_KEY_A    1
`define COMBO_KEY_B    11
`define COMBO_KEY_C    21
`define PIN_IDLE_LVL   1'b1

`define CLK_PERIOD_NS  4
`define DEBOUNCE_US    50
`define SCAN_MS        25
`define SETTLE_CYCLES  8
`define DEB_CYCLES     ((`DEBOUNCE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCAN_CYCLES    ((`SCAN_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define ADDR_STAT1     8'h11
`define ADDR_STAT2     8'h12
`define ADDR_STAT3     8'h13
`define ADDR_DATA1     8'h14
`define ADDR_DATA2     8'h15
`define ADDR_DATA3     8'h16
`define ADDR_DOUT1     8'h17
`define ADDR_DOUT2     8'h18
`define ADDR_DOUT3     8'h19
`define ADDR_IEN1      8'h1a
`define ADDR_IEN2      8'h1b
`define ADDR_IEN3      8'h1c
`define ADDR_SEL1      8'h1d
`define ADDR_SEL2      8'h1e
`define ADDR_SEL3      8'h1f
`define ADDR_DIR1      8'h23
`define ADDR_DIR2      8'h24
`define ADDR_DIR3      8'h25
`define ADDR_POL1      8'h26
`define ADDR_POL2      8'h27
`define ADDR_POL3      8'h28
`define ADDR_BYP1      8'h29
`define ADDR_BYP2      8'h30
`define ADDR_BYP3      8'h2b
`define ADDR_PULL1     8'h2c
`define ADDR_PULL2     8'h3d
`define ADDR_PULL3     8'h2e

`endif

// *** logic/kpd_pkg.sv ***
// Types shared by the keypad input conditioning design.
// Assumes kpd_defines.svh supplies all numeric constants.
`default_nettype none
package kpd_pkg;
  // Phases of the matrix scanner.
  typedef enum logic [1:0] {S_IDLE, S_DRIVE, S_FINISH, S_WAIT} scan_state_t;
endpackage
`default_nettype wire

// *** logic/input_filter.sv ***
// Per-pin stability filter with a per-pin bypass.
// Assumes the raw inputs are already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "kpd_defines.svh"
module input_filter
  import kpd_pkg::*;
#(
  parameter int WIDTH      = 19,
  parameter int DEB_CYCLES = `DEB_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] raw,
  input  wire logic [WIDTH-1:0] bypass,
  output logic      [WIDTH-1:0] filt
);
  localparam int            CW   = $clog2(DEB_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(DEB_CYCLES - 1);

  // Counters and accepted levels live together in one state word.
  typedef struct packed {
    logic [WIDTH-1:0][CW-1:0] cnt;
    logic [WIDTH-1:0]         lvl;
  } filt_state_t;

  filt_state_t st_reg;  // Registered state.
  filt_state_t st_next; // Next state.

  // A pin without bypass is accepted only once its new level held for the whole window.
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (bypass[i]) begin
        st_next.lvl[i] = raw[i];
        st_next.cnt[i] = '0;
      end else if (raw[i] == st_reg.lvl[i]) begin
        st_next.cnt[i] = '0; // A bounce back restarts the window.
      end else if (st_reg.cnt[i] == LAST) begin
        st_next.lvl[i] = raw[i];
        st_next.cnt[i] = '0;
      end else begin
        st_next.cnt[i] = CW'(st_reg.cnt[i] + 1'b1);
      end
    end
  end

  // Pins idle high, so the accepted level starts high to avoid a false event.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.cnt <= '0;
      st_reg.lvl <= {WIDTH{`PIN_IDLE_LVL}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign filt = st_reg.lvl;

  chk_bypass_follows: assert property (@(posedge clk) disable iff (!rst_n)
    bypass[0] |=> filt[0] == $past(raw[0]))
    else $error("bypassed pin did not follow its input");
  chk_stable_window: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(filt[0]) && !$past(bypass[0]) |-> $past(st_reg.cnt[0]) == LAST)
    else $error("filtered pin changed before the stable window ended");
endmodule
`default_nettype wire

// *** logic/keypad_input_conditioning.sv ***
// Keypad input conditioning: pin filters, matrix scanner and pin configuration registers.
// Assumes a byte-wide register port driven by the host bus engine, synchronous pins.
`timescale 1ns/1ps
`default_nettype none
`include "kpd_defines.svh"
module keypad_input_conditioning
  import kpd_pkg::*;
#(
  parameter int DEB_CYCLES   = `DEB_CYCLES,
  parameter int SCAN_CYCLES  = `SCAN_CYCLES,
  parameter int DWELL_CYCLES = `DEB_CYCLES + `SETTLE_CYCLES,
  parameter int HOLD_CYCLES  = `DEB_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [`NPINS-1:0]   pin_in,
  output logic      [`NPINS-1:0]   pin_out,
  output logic      [`NPINS-1:0]   pin_oe_n,
  output logic      [`NPINS-1:0]   pullup_en,
  input  wire logic                ext_reset_pin_n,
  output logic                     ext_reset_filt_n,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  input  wire logic                irq_clear_req,
  output logic                     input_change_flag,
  output logic                     input_change_irq_n,
  output logic      [`NKEYS-1:0]   key_map,
  output logic                     key_map_changed,
  output logic                     three_key_combo_alert
);
  localparam int NP = `NPINS;
  localparam int NR = `NROWS;
  localparam int DW = $clog2(DWELL_CYCLES + 1);
  localparam int PW = $clog2(SCAN_CYCLES + 1);
  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam logic [DW-1:0] DWELL_LAST = DW'(DWELL_CYCLES - 1);
  localparam logic [PW-1:0] SCAN_LAST  = PW'(SCAN_CYCLES - 1);
  localparam logic [HW-1:0] HOLD_LOAD  = HW'(HOLD_CYCLES);
  localparam logic [3:0]    LAST_COL   = 4'(`NCOLS - 1);

  // The whole state of the block outside the pin filters in one word.
  typedef struct packed {
    scan_state_t      st;          // Scanner phase.
    logic [3:0]       col;         // Column under test.
    logic [DW-1:0]    dwell;       // Cycles spent on this column.
    logic [PW-1:0]    period;      // Position inside the scan period.
    logic [HW-1:0]    hold;        // Interrupt release countdown.
    logic [`NKEYS-1:0] scan_map;   // Keys seen in the scan under way.
    logic [`NKEYS-1:0] prev_map;   // Keys seen in the last full scan.
    logic [`NKEYS-1:0] conf_map;   // Confirmed key states.
    logic             map_changed; // One-cycle pulse on a confirmed change.
    logic             combo;       // Three-key combination held.
    logic [NP-1:0]    dout;        // Output data.
    logic [NP-1:0]    ien;         // Interrupt enables.
    logic [NP-1:0]    sel;         // Matrix pin select.
    logic [NP-1:0]    dir;         // Direction, 1 is output.
    logic [NP-1:0]    pol;         // Trigger polarity.
    logic [NP-1:0]    byp;         // Filter bypass.
    logic [NP-1:0]    pull;        // Pullup off.
    logic [NP-1:0]    stat;        // Sticky input interrupt status.
    logic [7:0]       rdata;       // Read data.
  } core_t;

  core_t r;  // Registered state.
  core_t n;  // Next state.

  logic [NP:0]     filt;     // Filtered pins, reset pin on top.
  logic [NP-1:0]   trig;     // Input pins at their trigger level.
  logic [NR-1:0]   row_low;  // Matrix rows pulled low.
  logic [NP-1:0]   data_vw;  // Pin state as software sees it.
  logic [7:0]      rd_mux;   // Read data before the register.
  logic [`NCOLS-1:0] col_sel; // Pins chosen as matrix columns.

  // Byte write into an 18-bit group; the third byte keeps only two bits.
  function automatic logic [NP-1:0] grp_wr(input logic [NP-1:0] old,
                                           input logic [7:0]    a,
                                           input logic [7:0]    d,
                                           input logic [7:0]    a0,
                                           input logic [7:0]    a1,
                                           input logic [7:0]    a2);
    logic [NP-1:0] v;
    v = old;
    if (a == a0) begin
      v[7:0] = d;
    end
    if (a == a1) begin
      v[15:8] = d;
    end
    if (a == a2) begin
      v[17:16] = d[1:0];
    end
    return v;
  endfunction

  // Byte read of an 18-bit group; unused upper bits read zero.
  function automatic logic [7:0] grp_rd(input logic [NP-1:0] v,
                                        input logic [7:0]    a,
                                        input logic [7:0]    a0,
                                        input logic [7:0]    a1,
                                        input logic [7:0]    a2);
    logic [7:0] d;
    d = 8'h00;
    if (a == a0) begin
      d = v[7:0];
    end else if (a == a1) begin
      d = v[15:8];
    end else if (a == a2) begin
      d = {6'h00, v[17:16]};
    end
    return d;
  endfunction

  // Key number of a crossing; the map index is one less.
  function automatic logic [6:0] key_num(input logic [2:0] row,
                                         input logic [3:0] col);
    return 7'(row * `KEY_ROW_STRIDE + col + 1);
  endfunction

  // The reset pin never takes a bypass, so it is filtered in all cases.
  input_filter #(
    .WIDTH      (NP + 1),
    .DEB_CYCLES (DEB_CYCLES)
  ) u_filter (
    .clk    (clk),
    .rst_n  (rst_n),
    .raw    ({ext_reset_pin_n, pin_in}),
    .bypass ({1'b0, r.byp}),
    .filt   (filt)
  );

  assign col_sel = r.sel[NP-1:NR];
  assign row_low = r.sel[NR-1:0] & ~filt[NR-1:0];
  // Level trigger: a held active level re-arms the flag after each clear.
  assign trig = ~r.sel & ~r.dir & r.ien & ~(filt[NP-1:0] ^ r.pol);
  assign data_vw = (r.dir & r.dout) | (~r.dir & filt[NP-1:0]);

  // Read multiplexer; an unmapped address reads zero.
  assign rd_mux = grp_rd(r.stat, reg_addr, `ADDR_STAT1, `ADDR_STAT2, `ADDR_STAT3)
                | grp_rd(data_vw, reg_addr, `ADDR_DATA1, `ADDR_DATA2, `ADDR_DATA3)
                | grp_rd(r.dout, reg_addr, `ADDR_DOUT1, `ADDR_DOUT2, `ADDR_DOUT3)
                | grp_rd(r.ien, reg_addr, `ADDR_IEN1, `ADDR_IEN2, `ADDR_IEN3)
                | grp_rd(r.sel, reg_addr, `ADDR_SEL1, `ADDR_SEL2, `ADDR_SEL3)
                | grp_rd(r.dir, reg_addr, `ADDR_DIR1, `ADDR_DIR2, `ADDR_DIR3)
                | grp_rd(r.pol, reg_addr, `ADDR_POL1, `ADDR_POL2, `ADDR_POL3)
                | grp_rd(r.byp, reg_addr, `ADDR_BYP1, `ADDR_BYP2, `ADDR_BYP3)
                | grp_rd(r.pull, reg_addr, `ADDR_PULL1, `ADDR_PULL2, `ADDR_PULL3);

  // Next-state logic: registers, status, interrupt release and scanner.
  always_comb begin
    n = r;
    n.map_changed = 1'b0;
    if (reg_wr) begin
      n.dout = grp_wr(r.dout, reg_addr, reg_wdata, `ADDR_DOUT1, `ADDR_DOUT2, `ADDR_DOUT3);
      n.ien  = grp_wr(r.ien, reg_addr, reg_wdata, `ADDR_IEN1, `ADDR_IEN2, `ADDR_IEN3);
      n.sel  = grp_wr(r.sel, reg_addr, reg_wdata, `ADDR_SEL1, `ADDR_SEL2, `ADDR_SEL3);
      n.dir  = grp_wr(r.dir, reg_addr, reg_wdata, `ADDR_DIR1, `ADDR_DIR2, `ADDR_DIR3);
      n.pol  = grp_wr(r.pol, reg_addr, reg_wdata, `ADDR_POL1, `ADDR_POL2, `ADDR_POL3);
      n.byp  = grp_wr(r.byp, reg_addr, reg_wdata, `ADDR_BYP1, `ADDR_BYP2, `ADDR_BYP3);
      n.pull = grp_wr(r.pull, reg_addr, reg_wdata, `ADDR_PULL1, `ADDR_PULL2, `ADDR_PULL3);
    end
    // A status read clears the byte; new triggers below win over the clear.
    if (reg_rd) begin
      n.rdata = rd_mux;
      n.stat  = grp_wr(r.stat, reg_addr, 8'h00, `ADDR_STAT1, `ADDR_STAT2, `ADDR_STAT3);
    end
    n.stat = n.stat | trig;
    // Clearing with status still pending releases the line for a while.
    if (r.hold != '0) begin
      n.hold = HW'(r.hold - 1'b1);
    end
    if (irq_clear_req && (|r.stat)) begin
      n.hold = HOLD_LOAD;
    end
    case (r.st)
      S_IDLE: begin
        n.period = '0;
        if (|row_low) begin
          n.st       = S_DRIVE;
          n.col      = '0;
          n.dwell    = '0;
          n.scan_map = '0;
        end
      end
      S_DRIVE: begin
        n.period = PW'(r.period + 1'b1);
        if (!col_sel[r.col] || (r.dwell == DWELL_LAST)) begin
          // Rows are sampled raw of any ghost masking.
          if (col_sel[r.col]) begin
            for (int k = 0; k < NR; k++) begin
              n.scan_map[key_num(3'(k), r.col) - 7'h01] = row_low[k];
            end
          end
          n.dwell = '0;
          if (r.col == LAST_COL) begin
            n.st = S_FINISH;
          end else begin
            n.col = 4'(r.col + 1'b1);
          end
        end else begin
          n.dwell = DW'(r.dwell + 1'b1);
        end
      end
      S_FINISH: begin
        n.period   = PW'(r.period + 1'b1);
        n.prev_map = r.scan_map;
        // Column debounce: only two agreeing scans move the confirmed map.
        if ((r.scan_map == r.prev_map) && (r.scan_map != r.conf_map)) begin
          n.conf_map    = r.scan_map;
          n.map_changed = 1'b1;
          n.combo       = r.scan_map[`COMBO_KEY_A - 1] & r.scan_map[`COMBO_KEY_B - 1]
                        & r.scan_map[`COMBO_KEY_C - 1];
        end
        if ((r.scan_map == '0) && (n.conf_map == '0)) begin
          n.st = S_IDLE;
        end else begin
          n.st = S_WAIT;
        end
      end
      S_WAIT: begin
        if (r.period == SCAN_LAST) begin
          n.st       = S_DRIVE;
          n.period   = '0;
          n.col      = '0;
          n.dwell    = '0;
          n.scan_map = '0;
        end else begin
          n.period = PW'(r.period + 1'b1);
        end
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase
  end

  // All configuration defaults are zero; the scanner starts idle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r    <= '0;
      r.st <= S_IDLE;
    end else begin
      r <= n;
    end
  end

  // Pin drive: outputs drive their data, matrix columns drive low.
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      pin_out[i]  = 1'b0;
      pin_oe_n[i] = 1'b1;
      if (r.sel[i]) begin
        if ((i >= NR) && ((r.st != S_DRIVE) || (r.col == 4'(i - NR)))) begin
          pin_oe_n[i] = 1'b0;
        end
      end else if (r.dir[i]) begin
        pin_out[i]  = r.dout[i];
        pin_oe_n[i] = 1'b0;
      end
    end
  end

  // Pullups sit only on pins that are not being driven.
  assign pullup_en             = ~r.pull & pin_oe_n;
  assign ext_reset_filt_n      = filt[NP];
  assign reg_rdata             = r.rdata;
  assign input_change_flag     = |r.stat;
  assign input_change_irq_n    = ~(|r.stat) | (r.hold != '0);
  assign key_map               = r.conf_map;
  assign key_map_changed       = r.map_changed;
  assign three_key_combo_alert = r.combo;

  chk_low_trigger: assert property (@(posedge clk) disable iff (!rst_n)
    !r.sel[7] && !r.dir[7] && r.ien[7] && !r.pol[7] && !filt[7] |=> r.stat[7])
    else $error("low level did not set status");
  chk_high_trigger: assert property (@(posedge clk) disable iff (!rst_n)
    !r.sel[7] && !r.dir[7] && r.ien[7] && r.pol[7] && filt[7] |=> input_change_flag)
    else $error("high level did not raise the flag");
  chk_idle_cols_low: assert property (@(posedge clk) disable iff (!rst_n)
    r.st == S_IDLE |-> ((pin_oe_n[NP-1:NR] | pin_out[NP-1:NR]) & col_sel) == '0)
    else $error("idle matrix column not driven low");
  chk_one_col_low: assert property (@(posedge clk) disable iff (!rst_n)
    r.st == S_DRIVE |-> $onehot0(~pin_oe_n[NP-1:NR] & col_sel))
    else $error("more than one column driven in a scan");
  chk_row_wakes_scan: assert property (@(posedge clk) disable iff (!rst_n)
    r.st == S_IDLE && (|row_low) |=> r.st == S_DRIVE)
    else $error("low row did not start a scan");
  chk_two_scan_confirm: assert property (@(posedge clk) disable iff (!rst_n)
    r.st == S_FINISH && r.scan_map != r.prev_map |=> $stable(key_map))
    else $error("key map changed on a single scan");
  chk_scan_period: assert property (@(posedge clk) disable iff (!rst_n)
    r.st == S_WAIT && r.period == SCAN_LAST |=> r.st == S_DRIVE ##1 r.period == 1)
    else $error("scan did not restart at the period end");
  chk_irq_release: assert property (@(posedge clk) disable iff (!rst_n)
    irq_clear_req && input_change_flag |=> input_change_irq_n [*8])
    else $error("interrupt not released after an early clear");
  chk_combo_keys: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(three_key_combo_alert) |-> key_map[0] && key_map[10] && key_map[20])
    else $error("combination alert without its three keys");

  cov_key_change: cover property (@(posedge clk) disable iff (!rst_n) key_map_changed);
  cov_combo: cover property (@(posedge clk) disable iff (!rst_n) $rose(three_key_combo_alert));
  cov_rescan: cover property (@(posedge clk) disable iff (!rst_n)
    r.st == S_WAIT ##1 r.st == S_DRIVE);
  cov_release: cover property (@(posedge clk) disable iff (!rst_n)
    irq_clear_req && input_change_flag);
endmodule
`default_nettype wire

// *** tb/key_matrix_model.sv ***
// Key switch matrix and pin-side drivers facing the keypad conditioning block.
// Assumes rows on pins 7:0, columns on pins 17:8, and key bit k at row k/10, column k%10.
`timescale 1ns/1ps
`default_nettype none
module key_matrix_model (
  input  wire logic        clk,
  input  wire logic [17:0] pin_out,
  input  wire logic [17:0] pin_oe_n,
  input  wire logic [17:0] pullup_en,
  input  wire logic [17:0] ext_en,
  input  wire logic [17:0] ext_val,
  input  wire logic [79:0] pressed,
  output logic      [17:0] pin_in
);
  // A pin nobody drives and nothing pulls up toggles every cycle, so a stale level never passes.
  logic [17:0] float_reg = 18'h00000;
  always @(posedge clk) float_reg <= ~float_reg;
  // A low level spreads through every closed switch; repeated passes settle long chains.
  // This is what makes ghost crossings appear, as on a real matrix.
  always_comb begin : resolve
    logic [17:0] low;
    logic [17:0] high;
    low  = (~pin_oe_n & ~pin_out) | (ext_en & ~ext_val);
    high = (~pin_oe_n & pin_out) | (ext_en & ext_val) | pullup_en;
    for (int n = 0; n < 18; n++) begin
      for (int k = 0; k < 80; k++) begin
        // A closed switch ties its row and column together.
        if (pressed[k] && (low[k/10] || low[8+k%10])) begin
          low[k/10]    = 1'b1;
          low[8+k%10]  = 1'b1;
        end
      end
    end
    pin_in = ~low & (high | float_reg);
  end
endmodule
`default_nettype wire

// *** tb/keypad_input_conditioning_tb_top.sv ***
// Self-checking bench for the keypad input conditioning block with a switch matrix model.
// Assumes the shortened counts below; every expectation is derived from them.
`timescale 1ns/1ps
`default_nettype none
`include "kpd_defines.svh"
module keypad_input_conditioning_tb_top;
  import kpd_pkg::*;
  localparam int DEB  = 4;    // Shortened 50 us filter window.
  localparam int SCAN = 200;  // Shortened 25 ms scan period.
  localparam int HOLD = 10;   // Shortened interrupt release window.
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [17:0]       pin_in, pin_out, pin_oe_n, pullup_en;
  logic [17:0]       ext_en = 18'h00000;
  logic [17:0]       ext_val = 18'h00000;
  logic [79:0]       pressed = '0;
  logic [79:0]       key_map;
  logic              rpin_n = 1'b1;
  logic              rfilt_n, flag, irq_n, changed, alert;
  logic [7:0]        addr = 8'h00;
  logic [7:0]        wdata = 8'h00;
  logic [7:0]        rdata, d;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              clr = 1'b0;
  logic              single_seen = 1'b0;
  int                failures = 0;
  int                checks_done = 0;
  int                n;
  logic [7:0]        cfg [9] = '{8'h26, 8'h27, 8'h28, 8'h29, 8'h30, 8'h2b, 8'h2c, 8'h3d, 8'h2e};
  logic [79:0]       sets [4];
  always #2 clk = ~clk;
  keypad_input_conditioning #(.DEB_CYCLES(DEB), .SCAN_CYCLES(SCAN), .DWELL_CYCLES(10),
    .HOLD_CYCLES(HOLD)) dut (.clk(clk), .rst_n(rst_n), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .ext_reset_pin_n(rpin_n),
    .ext_reset_filt_n(rfilt_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .irq_clear_req(clr), .input_change_flag(flag),
    .input_change_irq_n(irq_n), .key_map(key_map), .key_map_changed(changed),
    .three_key_combo_alert(alert));
  key_matrix_model mdl (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pressed(pressed),
    .pin_in(pin_in));
  // Compares one result and counts it.
  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // Read data is registered on the same edge that takes the strobe.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    v = rdata;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask
  // Reference matrix: a crossing reads closed when its row and column share a switch path.
  function automatic logic [79:0] ghost(input logic [79:0] p);
    int g [18];
    logic [79:0] m;
    for (int i = 0; i < 18; i++) g[i] = i;
    repeat (18) for (int k = 0; k < 80; k++) if (p[k]) begin
      g[k/10]   = (g[k/10] < g[8+k%10]) ? g[k/10] : g[8+k%10];
      g[8+k%10] = g[k/10];
    end
    for (int k = 0; k < 80; k++) m[k] = p[k] || (g[k/10] == g[8+k%10]);
    return m;
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Two selected columns low at once would break the sweep.
  // Its own counter, so the matrix wait loop below is never disturbed.
  always @(negedge clk) begin : sweep_mon
    int lows;
    lows = 0;
    for (int c = 8; c < 11; c++) lows += (pin_oe_n[c] === 1'b0 && pin_out[c] === 1'b0);
    if (lows == 1) single_seen <= 1'b1;
    if (rst_n && lows == 2) check("column sweep", 1, 0);
  end
  // Cuts a hang short; the full run needs well under this span.
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    test_done();
  end
  initial begin
    void'($urandom(32'h5242faee));
    sets = '{80'h1 | 80'h400 | 80'h100000, 80'h0, 80'h1 | 80'h2 | 80'h400, 80'h0};
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    foreach (cfg[i]) begin
      rd_reg(cfg[i], d);
      check("reset value", d, 0);
      wdata = 8'($urandom);
      wr_reg(cfg[i], wdata);
      rd_reg(cfg[i], d);
      check("readback", d, wdata & ((cfg[i] == 8'h28 || cfg[i][3:0] == 4'he ||
        cfg[i] == 8'h2b) ? 8'h03 : 8'hff));
      wr_reg(cfg[i], 8'h00);
    end
    rd_reg(8'h3f, d);
    check("unmapped read", d, 0);
    check("pullups at reset", pullup_en, 18'h3ffff);
    wr_reg(8'h2c, 8'h80);
    wr_reg(8'h2e, 8'h02);
    check("pullup off", pullup_en, 18'h1ff7f);
    wr_reg(8'h2c, 8'h00);
    wr_reg(8'h2e, 8'h00);
    wr_reg(8'h23, 8'h40);
    wr_reg(8'h17, 8'h40);
    check("output pin", {pin_oe_n[6], pin_out[6]}, 2'b01);
    wr_reg(8'h23, 8'h00);
    $display("test registers done");
    ext_en[7] = 1'b1;
    ext_val[7] = 1'b1;
    wr_reg(8'h1a, 8'h80);
    rd_reg(8'h11, d);
    check("status idle", d, 0);
    ext_val[7] = 1'b0;
    cyc($urandom_range(1, DEB - 1));
    ext_val[7] = 1'b1;
    cyc(DEB + 4);
    check("glitch ignored", flag, 0);
    ext_val[7] = 1'b0;
    cyc(DEB - 1);
    check("early flag", flag, 0);
    cyc(6);
    check("low level flag", {flag, irq_n}, 2'b10);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(1);
    check("release window", irq_n, 1);
    cyc(HOLD + 2);
    check("reassert", irq_n, 0);
    wr_reg(8'h26, 8'h80);
    rd_reg(8'h11, d);
    check("status byte", d, 8'h80);
    check("cleared", flag, 0);
    ext_val[7] = 1'b1;
    cyc(DEB + 5);
    check("high level flag", flag, 1);
    wr_reg(8'h26, 8'h00);
    rd_reg(8'h11, d);
    wr_reg(8'h29, 8'h80);
    ext_val[7] = 1'b0;
    cyc(3);
    check("bypass flag", flag, 1);
    ext_en[7] = 1'b0;
    wr_reg(8'h1a, 8'h00);
    rd_reg(8'h11, d);
    $display("test input trigger done");
    wr_reg(8'h30, 8'hff);
    wr_reg(8'h2b, 8'h03);
    rpin_n = 1'b0;
    cyc($urandom_range(1, DEB - 1));
    rpin_n = 1'b1;
    cyc(DEB + 3);
    check("reset glitch", rfilt_n, 1);
    rpin_n = 1'b0;
    cyc(DEB + 4);
    check("reset taken", rfilt_n, 0);
    rpin_n = 1'b1;
    foreach (cfg[i]) wr_reg(cfg[i], 8'h00);
    $display("test reset filter done");
    wr_reg(8'h1d, 8'h0f);
    wr_reg(8'h1e, 8'h07);
    cyc(DEB + 2);
    check("idle drive", {pin_oe_n, pin_out}, {18'h3f8ff, 18'h0});
    foreach (sets[i]) begin
      pressed = sets[i];
      n = 0;
      // Step past the pulse of the previous set before looking for the next one.
      do begin
        @(negedge clk);
        n++;
      end while (n < 2 * SCAN + 80 && changed !== 1'b1);
      check("update in time", n < 2 * SCAN + 80, 1);
      check("two scans", n >= SCAN, 1);
      check("key map", key_map, ghost(sets[i]));
      check("combo", alert, sets[i] == sets[0]);
    end
    check("single column", single_seen, 1);
    $display("test matrix done");
    test_done();
  end
endmodule
`default_nettype wire
